// ==== hw/pbs_bit_serial.sv ====
// pulse-width bit serial assist: break-width timer, sync timer, capture/compare, APB regs
// Function
// - serial mode only when control bit 6 set
// - rising edge interrupt when control bit 8 set
// - break timer clears on fall, holds at rise
// - break timer runs from low-power clock tick
// - falling edge copies sync timer to capture
// - sync timer free-runs at high-speed rate
// - compare match sets status bit 3, interrupt
// - start interrupt on fall, wakes core
// - capture register 16 bits, read only
// - frame 19 bits at 1200 bit/s
// - low time fraction selects sync, zero, one
//
// Our own choices: the placing of the registers and register access over APB.
`timescale 1ns/1ps
`default_nettype none
module pbs_bit_serial
  import pbs_pkg::*;
#(
  parameter int SYNC_DIVIDE   = SYNC_DIV,
  parameter int LOWPWR_DIVIDE = LOWPWR_DIV
) (
  input  wire logic            clk,
  input  wire logic            rst_b,
  input  wire pbs_apb_req_type apbReq,
  output var  pbs_apb_rsp_type apbRsp,
  input  wire logic            busLine,
  output var  logic            irq,
  output var  logic            wake
);
  typedef struct packed {
    logic [1:0]           lineSync;
    logic                 lineDly;
    logic [CTL_WIDTH-1:0] control;
    logic [STA_WIDTH-1:0] status;
    logic [TMR_WIDTH-1:0] syncTimer;
    logic [TMR_WIDTH-1:0] breakTimer;
    logic                 breakRun;
    logic [TMR_WIDTH-1:0] captureVal;
    logic [TMR_WIDTH-1:0] compareVal;
    logic [31:0]          rdata;
    logic                 irq;
    logic                 wake;
  } pbs_state_type;

  pbs_state_type st;
  pbs_state_type next_st;
  logic          syncTick;
  logic          lpTick;

  pbs_tick_div #(.DIV(SYNC_DIVIDE)) u_sync_div (
    .clk  (clk),
    .rst_b(rst_b),
    .tick (syncTick)
  );

  // low-power oscillator modelled as a divided tick of the system clock
  pbs_tick_div #(.DIV(LOWPWR_DIVIDE)) u_lp_div (
    .clk  (clk),
    .rst_b(rst_b),
    .tick (lpTick)
  );

  logic                 fallEdge;
  logic                 riseEdge;
  logic                 modeOn;
  logic                 wrAcc;
  logic                 rdAcc;
  logic                 selControl;
  logic                 selStatus;
  logic                 selSyncTmr;
  logic                 selBreakTm;
  logic                 selCapture;
  logic                 selCompare;
  logic [TMR_WIDTH-1:0] syncPlusOne;
  logic                 cmpHit;
  logic                 cmpArmed;
  logic                 riseArmed;
  logic                 startArmed;
  logic                 breakFull;
  logic                 breakStep;
  logic [STA_WIDTH-1:0] setBits;
  logic [STA_WIDTH-1:0] clrBits;

  always_comb begin
    next_st = st;
    // edges from the second sync stage only, so a metastable first stage never reaches logic
    fallEdge = st.lineDly & ~st.lineSync[1];
    riseEdge = ~st.lineDly & st.lineSync[1];
    modeOn = st.control[CTL_PWM_MODE];
    wrAcc = apbReq.psel & apbReq.penable & apbReq.pwrite;
    rdAcc = apbReq.psel & ~apbReq.penable & ~apbReq.pwrite;
    // register select decode, shared by the write and read paths
    selControl = (apbReq.paddr == OFF_CONTROL);
    selStatus = (apbReq.paddr == OFF_STATUS);
    selSyncTmr = (apbReq.paddr == OFF_SYNCTMR);
    selBreakTm = (apbReq.paddr == OFF_BREAKTM);
    selCapture = (apbReq.paddr == OFF_CAPTURE);
    selCompare = (apbReq.paddr == OFF_COMPARE);
    // shared increment feeds both the timer and the match test
    syncPlusOne = st.syncTimer + 16'h0001;
    cmpHit = (syncPlusOne == st.compareVal);
    cmpArmed = modeOn & st.control[CTL_CMP_IE];
    riseArmed = modeOn & st.control[CTL_RISE_IE];
    startArmed = st.control[CTL_START_IE];
    breakFull = (st.breakTimer == 16'hFFFF);
    breakStep = st.breakRun & lpTick & ~breakFull;
    setBits = '0;
    clrBits = '0;

    next_st.lineSync = {st.lineSync[0], busLine};
    next_st.lineDly = st.lineSync[1];

    // sync timer only moves in serial mode and is never cleared there
    if (modeOn && syncTick) begin
      next_st.syncTimer = syncPlusOne;
    end
    // capture takes the count from before this edge's increment
    if (modeOn && fallEdge) begin
      next_st.captureVal = st.syncTimer;
    end
    // match on the tick that makes the timer equal to the compare word
    if (cmpArmed && syncTick && cmpHit) begin
      setBits[STA_CMP] = 1'b1;
    end

    // sixteen bits at the low-power rate outlast a whole bit period at the frame rate
    if (modeOn && fallEdge) begin
      next_st.breakTimer = '0;
      next_st.breakRun = 1'b1;
    end else if (riseEdge) begin
      next_st.breakRun = 1'b0;
    end else if (breakStep) begin
      next_st.breakTimer = st.breakTimer + 16'h0001;
    end
    if (riseArmed && riseEdge) begin
      setBits[STA_RISE] = 1'b1;
    end
    // start detect works outside serial mode too so it can wake the core
    if (startArmed && fallEdge) begin
      setBits[STA_START] = 1'b1;
    end

    // register writes take effect at the access edge only
    if (wrAcc && selControl) begin
      next_st.control = apbReq.pwdata[CTL_WIDTH-1:0];
    end
    if (wrAcc && selStatus) begin
      clrBits = apbReq.pwdata[STA_WIDTH-1:0];
    end
    if (wrAcc && selCompare) begin
      next_st.compareVal = apbReq.pwdata[TMR_WIDTH-1:0];
    end
    // set beats a simultaneous clear, so no event is lost to a late clear
    next_st.status = (st.status & ~clrBits) | setBits;

    // read data is registered at the setup edge and stands through the access phase
    if (rdAcc) begin
      next_st.rdata = 32'h00000000;
      if (selControl) begin
        next_st.rdata = 32'(st.control);
      end
      if (selStatus) begin
        next_st.rdata = 32'(st.status);
      end
      if (selSyncTmr) begin
        next_st.rdata = 32'(st.syncTimer);
      end
      if (selBreakTm) begin
        next_st.rdata = 32'(st.breakTimer);
      end
      if (selCapture) begin
        next_st.rdata = 32'(st.captureVal);
      end
      if (selCompare) begin
        next_st.rdata = 32'(st.compareVal);
      end
    end

    // one request line for all causes; software reads status to tell them apart
    next_st.irq = |next_st.status;
    next_st.wake = next_st.status[STA_START];
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      // line sync preset to the idle level so no false edge follows reset
      st.lineSync   <= 2'h3;
      st.lineDly    <= 1'b1;
      st.control    <= CTL_RESET;
      st.status     <= '0;
      st.syncTimer  <= '0;
      st.breakTimer <= '0;
      st.breakRun   <= 1'b0;
      st.captureVal <= '0;
      st.compareVal <= '0;
      st.rdata      <= '0;
      st.irq        <= 1'b0;
      st.wake       <= 1'b0;
    end else begin
      st <= next_st;
    end
  end

  always_comb begin
    apbRsp.prdata = st.rdata;
    apbRsp.pready = 1'b1;
    apbRsp.pslverr = 1'b0;
  end

  assign irq = st.irq;
  assign wake = st.wake;
endmodule : pbs_bit_serial
`default_nettype wire

// ==== hw/pbs_pkg.sv ====
// package: register map, field positions and timing constants of the bit serial assist
package pbs_pkg;
  // register byte offsets (our own map on APB)
  localparam logic [11:0] OFF_CONTROL = 12'h000;
  localparam logic [11:0] OFF_STATUS  = 12'h004;
  localparam logic [11:0] OFF_SYNCTMR = 12'h008;
  localparam logic [11:0] OFF_BREAKTM = 12'h00C;
  localparam logic [11:0] OFF_CAPTURE = 12'h010;
  localparam logic [11:0] OFF_COMPARE = 12'h014;
  // control field positions
  localparam int CTL_START_IE = 3;
  localparam int CTL_CMP_IE   = 5;
  localparam int CTL_PWM_MODE = 6;
  localparam int CTL_RISE_IE  = 8;
  localparam int CTL_WIDTH    = 9;
  // status field positions (write one to clear)
  localparam int STA_RISE  = 0;
  localparam int STA_START = 1;
  localparam int STA_CMP   = 3;
  localparam int STA_WIDTH = 4;
  localparam logic [CTL_WIDTH-1:0] CTL_RESET = 9'h000;
  // timer rates
  localparam int CLK_HZ      = 25_000_000;
  localparam int SYNC_HZ     = 5_000_000;
  localparam int LOWPWR_HZ   = 131_000;
  localparam int SYNC_DIV    = CLK_HZ / SYNC_HZ;
  localparam int LOWPWR_DIV  = CLK_HZ / LOWPWR_HZ;
  localparam int TMR_WIDTH   = 16;

  typedef struct packed {
    logic psel;
    logic penable;
    logic pwrite;
    logic [11:0] paddr;
    logic [31:0] pwdata;
  } pbs_apb_req_type;

  typedef struct packed {
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
  } pbs_apb_rsp_type;
endpackage : pbs_pkg

// ==== hw/pbs_tick_div.sv ====
// tick divider: one-cycle strobe every DIV clocks
`timescale 1ns/1ps
`default_nettype none
module pbs_tick_div
  import pbs_pkg::*;
#(
  parameter int DIV = 5
) (
  input  wire logic clk,
  input  wire logic rst_b,
  output var  logic tick
);
  typedef struct packed {
    logic [15:0] cnt;
    logic        tick;
  } pbs_div_type;
  pbs_div_type st;
  pbs_div_type next_st;

  always_comb begin
    next_st = st;
    next_st.tick = 1'b0;
    if (st.cnt == 16'(DIV - 1)) begin
      next_st.cnt = 16'h0000;
      next_st.tick = 1'b1;
    end else begin
      next_st.cnt = st.cnt + 16'h0001;
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign tick = st.tick;
endmodule : pbs_tick_div
`default_nettype wire

// ==== verification/pbs_bit_serial_sva.sv ====
// checker: port-level properties of the bit serial assist
`timescale 1ns/1ps
`default_nettype none
module pbs_bit_serial_sva
  import pbs_pkg::*;
(
  input wire logic            clk,
  input wire logic            rst_b,
  input wire pbs_apb_req_type apbReq,
  input wire pbs_apb_rsp_type apbRsp,
  input wire logic            busLine,
  input wire logic            irq,
  input wire logic            wake
);
  logic [8:0] ctl;
  // shadow of the control word, taken at the same edge as the design
  always_ff @(posedge clk or negedge rst_b)
    if (!rst_b) ctl <= '0;
    else if (apbReq.psel && apbReq.penable && apbReq.pwrite && apbReq.paddr == OFF_CONTROL)
      ctl <= apbReq.pwdata[8:0];
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_b);
  sequence fall_s; $fell(busLine) && ctl[CTL_START_IE]; endsequence
  sequence rise_s; $rose(busLine) && ctl[CTL_PWM_MODE] && ctl[CTL_RISE_IE]; endsequence
  ready_high_a: assert property (apbRsp.pready && !apbRsp.pslverr) else $error("bad answer");
  upper_zero_a: assert property (apbReq.psel && apbReq.penable |-> apbRsp.prdata[31:16] == 0)
    else $error("upper bits set");
  rdata_hold_a: assert property (apbReq.psel && apbReq.penable |=> $stable(apbRsp.prdata))
    else $error("read data moved");
  wake_irq_a: assert property (wake |-> irq) else $error("wake without irq");
  start_wake_a: assert property (fall_s |-> ##[3:5] wake) else $error("no wake");
  rise_irq_a: assert property (rise_s |-> ##[3:5] irq) else $error("no rise irq");
  wake_cause_a: assert property ($rose(wake) |-> !$past(busLine, 2))
    else $error("wake without fall");
  quiet_off_a: assert property (!ctl[CTL_PWM_MODE] && !ctl[CTL_START_IE] && !irq |=> !irq)
    else $error("irq while off");
endmodule : pbs_bit_serial_sva
bind pbs_bit_serial pbs_bit_serial_sva pbs_bit_serial_sva_i (.clk(clk), .rst_b(rst_b),
  .apbReq(apbReq), .apbRsp(apbRsp), .busLine(busLine), .irq(irq), .wake(wake));
`default_nettype wire

// ==== verification/pbs_bus_master.sv ====
// far-side bus master model: pulls the line low for a set width
`timescale 1ns/1ps
`default_nettype none
module pbs_bus_master (
  input wire logic clk,
  output var logic line
);
  // idle high, as the pull-up holds it
  initial line = 1'b1;
  task automatic send(input int lo, input int hi);
    line <= 1'b0;
    repeat (lo) @(posedge clk);
    line <= 1'b1;
    repeat (hi) @(posedge clk);
  endtask : send
endmodule : pbs_bus_master
`default_nettype wire

// ==== verification/tb.sv ====
// testbench for the pulse-width bit serial assist
`timescale 1ns/1ps
`default_nettype none
module tb;
  import pbs_pkg::*;
  logic            clk, rst_b, busLine, irq, wake;
  pbs_apb_req_type req;
  pbs_apb_rsp_type rsp;
  logic [31:0]     rd, cap;
  int              n_errors, samples_checked, seed, lw;
  // short low-power divide gives short breaks a count of several ticks
  pbs_bit_serial #(.LOWPWR_DIVIDE(4)) pbs_bit_serial_i (.clk(clk), .rst_b(rst_b),
    .apbReq(req), .apbRsp(rsp), .busLine(busLine), .irq(irq), .wake(wake));
  pbs_bus_master pbs_bus_master_i (.clk(clk), .line(busLine));
  initial begin
    clk = 0;
    forever #20 clk = ~clk;
  end
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    samples_checked++;
    if (g !== e) begin
      n_errors++;
      $display("[FAIL] %0t got %h exp %h", $time, g, e);
    end
  endtask : chk
  task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d);
    req <= '{1'b1, 1'b0, w, a, d};
    @(posedge clk) req.penable <= 1'b1;
    do @(posedge clk); while (rsp.pready !== 1'b1);
    rd = rsp.prdata;
    req <= '0;
    @(posedge clk);
  endtask : xfer
  task automatic finish_test;
    $display("checks %0d errors %0d", samples_checked, n_errors);
    if (n_errors == 0 && samples_checked > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : finish_test
  initial begin
    repeat (20000) @(posedge clk);
    n_errors++;
    finish_test();
  end
  initial begin
    seed = 32'h0B3F;
    req = '0;
    rst_b = 0;
    repeat (10) @(posedge clk);
    rst_b <= 1;
    @(posedge clk);
    xfer(0, OFF_CONTROL, 0); chk(rd, 0);
    pbs_bus_master_i.send(30, 30);
    xfer(0, OFF_CAPTURE, 0); chk(rd, 0);
    xfer(0, 12'h020, 0); chk(rd, 0);
    $display("test mode off done");
    xfer(1, OFF_CONTROL, 32'h148);
    repeat (4) begin
      lw = 8 + ($random(seed) & 63);
      pbs_bus_master_i.send(lw, 20);
      xfer(0, OFF_BREAKTM, 0); chk(32'(rd inside {[lw/4-1:lw/4+1]}), 1);
      xfer(0, OFF_STATUS, 0); chk(rd & 3, 3);
      chk(32'(irq), 1);
      xfer(1, OFF_STATUS, 3);
      @(posedge clk);
      chk(32'(wake), 0);
    end
    $display("test receive done");
    xfer(1, OFF_CONTROL, 32'h168);
    pbs_bus_master_i.send(10, 0);
    xfer(0, OFF_CAPTURE, 0);
    cap = rd;
    // compare sits 30 sync ticks past the captured count
    xfer(1, OFF_COMPARE, cap + 30);
    xfer(1, OFF_STATUS, 32'h0B);
    xfer(0, OFF_STATUS, 0); chk(rd & 8, 0);
    repeat (160) @(posedge clk);
    xfer(0, OFF_STATUS, 0); chk(rd & 8, 8);
    chk(32'(irq), 1);
    xfer(0, OFF_SYNCTMR, 0); chk(32'(rd > cap), 1);
    xfer(1, OFF_CAPTURE, 32'hFFFF);
    xfer(0, OFF_CAPTURE, 0); chk(rd, cap);
    $display("test transmit done");
    finish_test();
  end
endmodule : tb
`default_nettype wire
